// >>> verilog/sttc_defs.svh
/*
 sttc_defs.svh: named constants of the total-configuration store block,
 frame byte positions, store layout, register offsets and field bits.
 Assumes inclusion by its bare name from the block's design files.
*/
`ifndef STTC_DEFS_SVH
`define STTC_DEFS_SVH

// command frame layout
`define STTC_CMD_STORE     8'h3A
`define STTC_FB_CMD        8'h00
`define STTC_FB_ZERO       8'h01
`define STTC_FB_FIRST      8'h02
`define STTC_FB_CFG        8'h0A
`define STTC_FB_PARAM      8'h8A
`define STTC_FB_PARAM_END  8'hA9
`define STTC_ZERO_BYTE     8'h00

// store layout (store index = frame byte - 2)
`define STTC_ST_LAST       8'hA9
`define STTC_ST_PARAM      8'h88
`define STTC_ST_FLAG1      8'hA8
`define STTC_ST_FLAG2      8'hA9

// profile whose parameters the master manages itself
`define STTC_PROFILE_74    8'h47
`define STTC_MANAGED_PARAM 4'hF
`define STTC_FW_V3         8'h03

// parameter walk over all 64 slots
`define STTC_NIB_LAST      6'h3F
`define STTC_RSVD_MASK     64'h0000_0001_0000_0001
`define STTC_FLAG_A_BIT    0

// register map (byte addresses)
`define STTC_A_CTRL        12'h100
`define STTC_A_STATUS      12'h104
`define STTC_A_FLAGS       12'h108
`define STTC_A_MAP_A       12'h10C
`define STTC_A_MAP_B       12'h110

// control and status bits
`define STTC_CTRL_GO       0
`define STTC_CTRL_PROT     1
`define STTC_CTRL_BOOT     2
`define STTC_STS_BUSY      0
`define STTC_STS_DONE      1
`define STTC_STS_ERR_CMD   2
`define STTC_STS_ERR_ZERO  3
`define STTC_STS_ERR_REF   4
`define STTC_STS_BOOT      5

`endif

// >>> verilog/sttc_pkg.sv
/*
 sttc_pkg: types of the total-configuration store block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package sttc_pkg;
	// sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_COPY, ST_BOOT} sttc_state_t;

	// whole state of the command block
	typedef struct packed {
		sttc_state_t state;     // sequencer state
		logic [7:0]  idx;       // store byte being written
		logic [5:0]  nib;       // parameter slot walked at start-up
		logic        boot_pend; // start-up walk requested
		logic        prot;      // protected operation selected
		logic        done;      // last job finished
		logic        err_cmd;   // wrong command code
		logic        err_zero;  // byte 1 not zero
		logic        err_ref;   // refused in protected operation
		logic        pv;        // parameter offered to the slave side
		logic [5:0]  paddr;     // slot of offered parameter
		logic [3:0]  pval;      // offered parameter value
		logic        dp_valid;  // ahb data phase pending
		logic        dp_write;  // pending phase is a write
		logic [11:0] dp_addr;   // pending phase address
	} sttc_regs_t;
endpackage
`default_nettype wire

// >>> verilog/sttc_nv_store.sv
/*
 sttc_nv_store: non-volatile expected-configuration store, one byte per
 stored frame byte, with decoded bitmap and flag views.
 Assumes a single writer and the system clock; content survives rst.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sttc_defs.svh"
module sttc_nv_store #(
	parameter int BYTES = 170 // stored frame bytes 2..171
) (
	input  wire logic        clk_sys, // system clock
	input  wire logic        ce,      // clock enable
	input  wire logic        we,      // byte write strobe
	input  wire logic [7:0]  waddr,   // byte index to write
	input  wire logic [7:0]  wdata,   // byte to write
	input  wire logic [7:0]  raddr,   // byte index to read
	output logic      [7:0]  rdata,   // byte read
	output logic      [63:0] bitmap,  // configured slaves, a then b
	output logic      [15:0] flags    // stored flag bytes 2 and 1
);
	// storage cells, blank after power-up
	logic [7:0] mem [BYTES];

	if (BYTES < 170) begin : g_bad_depth
		$error("store too small for a full configuration");
	end

	// power-up content of a blank part
	initial begin
		for (int i = 0; i < BYTES; i++) begin
			mem[i] = `STTC_ZERO_BYTE;
		end
	end

	// writes replace the old byte; rst leaves them alone
	always_ff @(posedge clk_sys) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	// read port and flag view
	assign rdata = mem[raddr];
	assign flags = {mem[`STTC_ST_FLAG2], mem[`STTC_ST_FLAG1]};

	// address i sits in byte i/8, from bit 7 down
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			bitmap[i] = mem[i / 8][7 - (i % 8)];
		end
	end
endmodule // sttc_nv_store
`default_nettype wire

// >>> verilog/sttc_cmd.sv
/*
 sttc_cmd: ahb-lite command block that takes the store-total-configuration
 job frame, checks it and commits it to the non-volatile store, then
 serves bitmap, flags and start-up parameter delivery.
 Assumes one ahb-lite master, word transfers only, synchronous inputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sttc_defs.svh"
module sttc_cmd #(
	parameter int         FRAME_WORDS = 55,   // frame window in words
	parameter logic [7:0] FW_MAJOR    = 8'h03 // firmware major revision
) (
	input  wire logic        clk_sys,        // system clock, 50 MHz
	input  wire logic        rst,            // sync reset, active high
	input  wire logic        ce,             // clock enable, freezes all
	input  wire logic        hsel,           // ahb slave select
	input  wire logic [31:0] haddr,          // ahb address
	input  wire logic [1:0]  htrans,         // ahb transfer type
	input  wire logic        hwrite,         // ahb write
	input  wire logic [2:0]  hsize,          // ahb size, word only
	input  wire logic [31:0] hwdata,         // ahb write data
	input  wire logic        hready,         // ahb bus ready
	output logic             hreadyout,      // ahb slave ready
	output logic             hresp,          // ahb response, always okay
	output logic      [31:0] hrdata,         // ahb read data
	output logic      [63:0] slave_activate, // slaves allowed to run
	output logic      [15:0] op_flags,       // stored start-up flags
	output logic             flag_a,         // flag_a flag
	output logic             param_valid,    // parameter offered
	output logic      [5:0]  param_addr,     // slot, bit 5 = b slave
	output logic      [3:0]  param_value,    // parameter to send
	input  wire logic        param_ready     // slave side takes it
);
	import sttc_pkg::*;

	if (FRAME_WORDS < 43 || FRAME_WORDS > 64) begin : g_bad_frame
		$error("frame window must hold 172 to 256 bytes");
	end

	// state and its next value
	sttc_regs_t s_reg;
	sttc_regs_t s_next;
	// job frame as written by the host
	logic [31:0] frame_mem [FRAME_WORDS];

	// store port
	logic        st_we;    // store write strobe
	logic [7:0]  st_wdata; // byte to store
	logic [7:0]  st_raddr; // byte to read
	logic [7:0]  st_rdata; // byte read
	logic [63:0] st_map;   // stored bitmap
	// decode helpers
	logic        ap;       // address phase taken
	logic        wr;       // write data phase now
	logic        ctrl_wr;  // control register written
	logic        frame_wr; // frame word written
	logic        frame_hit;// pending address inside frame
	logic [7:0]  f;        // frame byte being copied
	logic        in_par;   // copied byte is a parameter byte
	logic [5:0]  n_hi;     // slot in high nibble
	logic [5:0]  n_lo;     // slot in low nibble
	logic        p74_hi;   // high slot managed by master
	logic        p74_lo;   // low slot managed by master
	logic        job_ok;   // checked job may be stored

	// one frame byte; first byte of a word in bits 7..0
	function automatic logic [7:0] fbyte(input logic [7:0] i);
		return frame_mem[i[7:2]][{i[1:0], 3'b000} +: 8];
	endfunction

	// slot uses profile 7.4 (cfg byte at 10 + 2n)
	function automatic logic is_p74(input logic [5:0] n);
		return fbyte(`STTC_FB_CFG + {1'b0, n, 1'b0}) == `STTC_PROFILE_74;
	endfunction

	// bus decode
	assign ap        = hsel && htrans[1] && hready;
	assign wr        = s_reg.dp_valid && s_reg.dp_write;
	assign ctrl_wr   = wr && (s_reg.dp_addr == `STTC_A_CTRL);
	assign frame_hit = s_reg.dp_addr[11:2] < 10'(FRAME_WORDS);
	// frame is locked while a job runs
	assign frame_wr  = wr && frame_hit && (s_reg.state == ST_IDLE);
	assign hreadyout = ce;
	assign hresp     = 1'b0;

	// copy path: frame byte idx + 2 lands in store byte idx
	assign f      = s_reg.idx + `STTC_FB_FIRST;
	assign in_par = (f >= `STTC_FB_PARAM) && (f <= `STTC_FB_PARAM_END);
	assign n_hi   = {f[4:0] - 5'(`STTC_FB_PARAM), 1'b0};
	assign n_lo   = {f[4:0] - 5'(`STTC_FB_PARAM), 1'b1};
	// reserved slot 0 / 0b carries no slave
	assign p74_hi = in_par && (n_hi[4:0] != 5'h00) && is_p74(n_hi);
	assign p74_lo = in_par && is_p74(n_lo);

	// managed nibbles replaced, others stored as received
	always_comb begin
		st_wdata = fbyte(f);
		if (p74_hi) begin
			st_wdata[7:4] = `STTC_MANAGED_PARAM;
		end
		if (p74_lo) begin
			st_wdata[3:0] = `STTC_MANAGED_PARAM;
		end
	end

	// protected job allowed only from firmware v3 on
	assign job_ok = !s_reg.prot || (FW_MAJOR >= `STTC_FW_V3);

	// parameter byte of the walked slot (store byte 136 + n/2 for a and b)
	assign st_raddr = `STTC_ST_PARAM + {3'b000, s_reg.nib[5:1]};

	// sequencer and bus bookkeeping
	always_comb begin
		s_next = s_reg;
		st_we  = 1'b0;
		// address phase capture
		s_next.dp_valid = ap;
		if (ap) begin
			s_next.dp_write = hwrite;
			s_next.dp_addr  = haddr[11:0];
		end
		// mode bit
		if (ctrl_wr) begin
			s_next.prot = hwdata[`STTC_CTRL_PROT];
		end
		unique case (s_reg.state)
			ST_IDLE: begin
				// a new job wins over a pending start-up
				if (ctrl_wr && hwdata[`STTC_CTRL_GO]) begin
					s_next.state    = ST_CHECK;
					s_next.done     = 1'b0;
					s_next.err_cmd  = 1'b0;
					s_next.err_zero = 1'b0;
					s_next.err_ref  = 1'b0;
				end else if (s_reg.boot_pend) begin
					s_next.state     = ST_BOOT;
					s_next.nib       = 6'h00;
					s_next.boot_pend = 1'b0;
				end
			end
			ST_CHECK: begin
				s_next.state = ST_IDLE;
				if (fbyte(`STTC_FB_CMD) != `STTC_CMD_STORE) begin
					s_next.err_cmd = 1'b1;
					s_next.done    = 1'b1;
				end else if (fbyte(`STTC_FB_ZERO) != `STTC_ZERO_BYTE) begin
					s_next.err_zero = 1'b1;
					s_next.done     = 1'b1;
				end else if (!job_ok) begin
					s_next.err_ref = 1'b1;
					s_next.done    = 1'b1;
				end else begin
					s_next.state = ST_COPY;
					s_next.idx   = 8'h00;
				end
			end
			ST_COPY: begin
				// one byte per cycle overwrites the old config
				st_we = 1'b1;
				if (s_reg.idx == `STTC_ST_LAST) begin
					s_next.state = ST_IDLE;
					s_next.done  = 1'b1;
				end else begin
					s_next.idx = s_reg.idx + 8'h01;
				end
			end
			ST_BOOT: begin
				if (s_reg.pv) begin
					// hold the offer until the slave side takes it
					if (param_ready) begin
						s_next.pv = 1'b0;
						if (s_reg.nib == `STTC_NIB_LAST) begin
							s_next.state = ST_IDLE;
						end else begin
							s_next.nib = s_reg.nib + 6'h01;
						end
					end
				end else if (s_reg.nib[4:0] == 5'h00) begin
					// reserved slots 0 and 0b are skipped
					s_next.nib = s_reg.nib + 6'h01;
				end else begin
					// even slot in high nibble, odd in low
					s_next.pv    = 1'b1;
					s_next.paddr = s_reg.nib;
					s_next.pval  = s_reg.nib[0] ? st_rdata[3:0] : st_rdata[7:4];
				end
			end
		endcase
		// start-up request, set after the idle clear
		if (ctrl_wr && hwdata[`STTC_CTRL_BOOT]) begin
			s_next.boot_pend = 1'b1;
		end
	end

	// state register; a start-up walk follows reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg           <= '0;
			s_reg.state     <= ST_IDLE;
			s_reg.boot_pend <= 1'b1;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// frame words from the host
	always_ff @(posedge clk_sys) begin
		if (ce && frame_wr) begin
			frame_mem[s_reg.dp_addr[7:2]] <= hwdata;
		end
	end

	// read mux, unmapped reads as zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (s_reg.dp_valid && !s_reg.dp_write) begin
			if (frame_hit) begin
				hrdata = frame_mem[s_reg.dp_addr[7:2]];
			end else begin
				unique case (s_reg.dp_addr)
					`STTC_A_CTRL: hrdata[`STTC_CTRL_PROT] = s_reg.prot;
					`STTC_A_STATUS: begin
						hrdata[`STTC_STS_BUSY]     = s_reg.state != ST_IDLE;
						hrdata[`STTC_STS_DONE]     = s_reg.done;
						hrdata[`STTC_STS_ERR_CMD]  = s_reg.err_cmd;
						hrdata[`STTC_STS_ERR_ZERO] = s_reg.err_zero;
						hrdata[`STTC_STS_ERR_REF]  = s_reg.err_ref;
						hrdata[`STTC_STS_BOOT]     = s_reg.boot_pend;
					end
					`STTC_A_FLAGS: hrdata[15:0] = op_flags;
					`STTC_A_MAP_A: hrdata = st_map[31:0];
					`STTC_A_MAP_B: hrdata = st_map[63:32];
					default: hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// non-volatile expected configuration
	sttc_nv_store u_store (
		.clk_sys (clk_sys),
		.ce      (ce),
		.we      (st_we),
		.waddr   (s_reg.idx),
		.wdata   (st_wdata),
		.raddr   (st_raddr),
		.rdata   (st_rdata),
		.bitmap  (st_map),
		.flags   (op_flags)
	);

	// protected: only configured; otherwise every real address
	assign slave_activate = (s_reg.prot ? st_map : ~64'h0) & ~`STTC_RSVD_MASK;
	assign flag_a         = op_flags[`STTC_FLAG_A_BIT];
	assign param_valid    = s_reg.pv;
	assign param_addr     = s_reg.paddr;
	assign param_value    = s_reg.pval;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// check step leads to either an error or the copy
	sequence s_check_ce;
		s_reg.state == ST_CHECK && ce;
	endsequence

	property p_cmd_reject;
		s_check_ce and (fbyte(`STTC_FB_CMD) != `STTC_CMD_STORE) |=>
			s_reg.err_cmd && s_reg.done && s_reg.state == ST_IDLE;
	endproperty
	a_cmd_reject: assert property (p_cmd_reject) else $error("bad code not refused");

	property p_refuse_old;
		s_check_ce and (fbyte(`STTC_FB_CMD) == `STTC_CMD_STORE) and
			(fbyte(`STTC_FB_ZERO) == `STTC_ZERO_BYTE) and s_reg.prot |=>
			(FW_MAJOR < `STTC_FW_V3) ? s_reg.err_ref : s_reg.state == ST_COPY;
	endproperty
	a_refuse_old: assert property (p_refuse_old) else $error("protected job misjudged");

	property p_accept_cfg;
		s_check_ce and (fbyte(`STTC_FB_CMD) == `STTC_CMD_STORE) and
			(fbyte(`STTC_FB_ZERO) == `STTC_ZERO_BYTE) and !s_reg.prot |=>
			s_reg.state == ST_COPY && s_reg.idx == 8'h00;
	endproperty
	a_accept_cfg: assert property (p_accept_cfg) else $error("valid job not copied");

	property p_copy_run;
		$rose(s_reg.state == ST_COPY) && ce |-> (st_we && ce)[*1] ##1 (s_reg.state == ST_COPY);
	endproperty
	a_copy_run: assert property (p_copy_run) else $error("copy stopped early");

	property p_activate;
		s_reg.prot |-> (slave_activate & ~st_map) == 64'h0 && !slave_activate[0];
	endproperty
	a_activate: assert property (p_activate) else $error("unconfigured slave active");

	property p_param_hold;
		param_valid && !param_ready && ce |=>
			param_valid && $stable(param_addr) && $stable(param_value);
	endproperty
	a_param_hold: assert property (p_param_hold) else $error("offer dropped");

	property p_param_slot;
		param_valid |-> param_addr[4:0] != 5'h00;
	endproperty
	a_param_slot: assert property (p_param_slot) else $error("reserved slot sent");

	property p_flag_store;
		st_we && ce && s_reg.idx == `STTC_ST_FLAG1 |=> op_flags[7:0] == $past(st_wdata);
	endproperty
	a_flag_store: assert property (p_flag_store) else $error("flag byte not stored");

	property p_managed;
		st_we && p74_hi |-> st_wdata[7:4] == `STTC_MANAGED_PARAM;
	endproperty
	a_managed: assert property (p_managed) else $error("profile 7.4 value kept");
endmodule // sttc_cmd
`default_nettype wire

// >>> verif/sttc_param_sink.sv
/*
 sttc_param_sink: slave-side model that takes start-up parameters and keeps
 every slot and value it was handed, answering promptly or slowly.
 Assumes the system clock and synchronous active-high reset of the block.
*/
`timescale 1ns/1ns
`default_nettype none
module sttc_param_sink (
	input  wire logic       clk_sys,     // system clock
	input  wire logic       rst,         // sync reset, active high
	input  wire logic       slow,        // answer only every other edge
	input  wire logic       param_valid, // parameter offered
	input  wire logic [5:0] param_addr,  // offered slot
	input  wire logic [3:0] param_value, // offered value
	output logic            param_ready  // parameter taken
);
	logic [5:0] got_a[$]; // slots received in order
	logic [3:0] got_v[$]; // values received in order

	// ready pattern and capture of each handed-over parameter
	always @(posedge clk_sys) begin
		if (!rst && param_valid && param_ready) begin
			got_a.push_back(param_addr);
			got_v.push_back(param_value);
		end
		if (rst) begin
			param_ready <= 1'b0;
		end else begin
			param_ready <= slow ? ~param_ready : 1'b1;
		end
	end
endmodule // sttc_param_sink
`default_nettype wire

// >>> verif/store_total_config_cmd_bench.sv
/*
 store_total_config_cmd_bench: self-checking bench of the configuration
 store block, one task per scenario, over ahb-lite word transfers.
 Assumes the block's package, constants and a parameter sink model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sttc_defs.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin num_errors++; \
	$display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module store_total_config_cmd_bench;
	import sttc_pkg::*;
	localparam logic [31:0] MAP_A  = 32'h8000_0122; // slaves 1, 5, 8, 31
	localparam logic [31:0] MAP_B  = 32'h4000_0082; // slaves 1b, 7b, 30b
	localparam logic [31:0] MAP_A2 = 32'h0000_1002; // slaves 1, 12
	localparam logic [31:0] MAP_X  = 32'h0000_00F0; // map of faulty jobs
	localparam logic [7:0]  FL1    = 8'hA5;         // flag byte 1
	localparam logic [7:0]  FL2    = 8'h3C;         // flag byte 2
	logic        clk_sys, rst, hsel, hsel2, hwrite, slow, tgt; // bench drives
	logic        ce;              // clock enable of both blocks
	logic [31:0] haddr, hwdata;   // address and write data
	logic [1:0]  htrans;          // transfer type
	logic [2:0]  hsize;           // transfer size
	logic        hreadyout, hreadyout2, hresp, flag_a, param_valid, param_ready;
	logic [31:0] hrdata, hrdata2; // read data of both slaves
	logic [63:0] slave_activate;  // activation view
	logic [15:0] op_flags;        // stored flags
	logic [5:0]  param_addr;      // offered slot
	logic [3:0]  param_value;     // offered value
	logic [7:0]  frm [0:171];     // frame image
	logic [31:0] st, q;           // status and read results
	int          num_errors, check_count; // counters

	// block under test, new firmware
	sttc_cmd sttc_cmd_i (.clk_sys(clk_sys), .rst(rst),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .slave_activate(slave_activate), .op_flags(op_flags), .flag_a(flag_a),
		.param_valid(param_valid), .param_addr(param_addr), .param_value(param_value),
		.param_ready(param_ready));
	// second copy with old firmware, for refusal in protected operation
	sttc_cmd #(.FW_MAJOR(8'h02)) sttc_cmd_v2_i (.clk_sys(clk_sys), .rst(rst),
		.ce(ce), .hsel(hsel2), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout2), .hreadyout(hreadyout2), .hresp(), .hrdata(hrdata2),
		.slave_activate(), .op_flags(), .flag_a(), .param_valid(), .param_addr(),
		.param_value(), .param_ready(1'b1));
	// slave side of the parameter link
	sttc_param_sink sttc_param_sink_i (.clk_sys(clk_sys), .rst(rst), .slow(slow),
		.param_valid(param_valid), .param_addr(param_addr), .param_value(param_value),
		.param_ready(param_ready));

	// 50 mhz clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// one word transfer, address phase then data phase
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		hsel   <= !tgt;
		hsel2  <= tgt;
		haddr  <= {20'h00000, a};
		hwrite <= w;
		hsize  <= 3'h2;
		htrans <= 2'h2;
		do @(posedge clk_sys); while ((tgt ? hreadyout2 : hreadyout) !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hsel2  <= 1'b0;
		hwdata <= d;
		do @(posedge clk_sys); while ((tgt ? hreadyout2 : hreadyout) !== 1'b1);
		r = tgt ? hrdata2 : hrdata;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0000_0000, r);
	endtask

	// parameter pattern of slot n
	function automatic logic [3:0] pv(input int n);
		return n[3:0] ^ 4'hA;
	endfunction

	// frame image: code, byte 1, bitmaps, slave 5 on profile 7.4, params, flags
	task build(input logic [7:0] cmd, input logic [7:0] b1, input logic [31:0] ma);
		int n;
		foreach (frm[i]) frm[i] = 8'h00;
		frm[0] = cmd;
		frm[1] = b1;
		for (n = 1; n < 32; n++) begin
			frm[2 + n / 8][7 - n % 8] = ma[n];
			frm[6 + n / 8][7 - n % 8] = MAP_B[n];
		end
		frm[20] = 8'h47;
		for (n = 1; n < 64; n++) begin
			if (n % 2 == 1) frm[138 + n / 2][3:0] = pv(n);
			else if (n != 32) frm[138 + n / 2][7:4] = pv(n);
		end
		frm[170] = FL1;
		frm[171] = FL2;
		for (n = 0; n < 43; n++)
			wr(12'(4 * n), {frm[4 * n + 3], frm[4 * n + 2], frm[4 * n + 1], frm[4 * n]});
	endtask

	// start a job and poll status until not busy
	task job(input logic [31:0] c);
		int k;
		wr(`STTC_A_CTRL, c);
		st = 32'h0000_0001;
		for (k = 0; k < 300 && st[0] !== 1'b0; k++) rd(`STTC_A_STATUS, st);
	endtask

	// collect one start-up walk and compare slots and values
	task walk(input logic stored, input logic s, input logic [31:0] c);
		int k, n, i;
		slow <= s;
		if (c != 32'h0) begin
			sttc_param_sink_i.got_a.delete();
			sttc_param_sink_i.got_v.delete();
			wr(`STTC_A_CTRL, c);
		end
		for (k = 0; k < 2000 && sttc_param_sink_i.got_a.size() < 62; k++) @(posedge clk_sys);
		repeat (12) @(posedge clk_sys);
		`CHK("walk count", 62, sttc_param_sink_i.got_a.size())
		i = 0;
		for (n = 1; n < 64; n++) if (n != 32 && i < sttc_param_sink_i.got_a.size()) begin
			`CHK("slot", 6'(n), sttc_param_sink_i.got_a[i])
			`CHK("param", stored ? (n == 5 ? 4'hF : pv(n)) : 4'h0, sttc_param_sink_i.got_v[i])
			i++;
		end
	endtask

	// good job in configuration operation, then read back its views
	task t_store;
		build(8'h3A, 8'h00, MAP_A);
		job(32'h0000_0001);
		`CHK("status", 5'h02, st[4:0])
		rd(`STTC_A_MAP_A, q);
		`CHK("map a", MAP_A, q)
		rd(`STTC_A_MAP_B, q);
		`CHK("map b", MAP_B, q)
		rd(`STTC_A_FLAGS, q);
		`CHK("flags", {FL2, FL1}, q[15:0])
		`CHK("op flags", {FL2, FL1}, op_flags)
		`CHK("flag a", FL1[0], flag_a)
		`CHK("all active", 64'hFFFF_FFFE_FFFF_FFFE, slave_activate)
		wr(`STTC_A_CTRL, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		`CHK("protected active", {MAP_B, MAP_A}, slave_activate)
	endtask

	// faulty jobs leave the stored configuration alone
	task t_bad;
		build(8'h3B, 8'h00, MAP_X);
		job(32'h0000_0003);
		`CHK("status code", 5'h06, st[4:0])
		build(8'h3A, 8'h01, MAP_X);
		job(32'h0000_0003);
		`CHK("status byte1", 5'h0A, st[4:0])
		rd(`STTC_A_MAP_A, q);
		`CHK("map kept", MAP_A, q)
	endtask

	// new firmware stores while protected; old firmware refuses
	task t_prot;
		build(8'h3A, 8'h00, MAP_A2);
		job(32'h0000_0003);
		`CHK("status prot", 5'h02, st[4:0])
		`CHK("new active", {MAP_B, MAP_A2}, slave_activate)
		tgt = 1'b1;
		// the old-firmware copy needs its own frame image
		build(8'h3A, 8'h00, MAP_A2);
		job(32'h0000_0003);
		`CHK("status old", 5'h12, st[4:0])
		rd(`STTC_A_MAP_A, q);
		`CHK("old map", 32'h0000_0000, q)
		job(32'h0000_0001);
		rd(`STTC_A_MAP_A, q);
		`CHK("old map cfg", MAP_A2, q)
		tgt = 1'b0;
		rd(12'h1F0, q);
		`CHK("unmapped", 32'h0000_0000, q)
		`CHK("hresp", 1'b0, hresp)
		// clock enable low stalls the bus and freezes the views
		q = slave_activate[31:0];
		ce <= 1'b0;
		repeat (3) @(posedge clk_sys);
		`CHK("frozen ready", 1'b0, hreadyout)
		`CHK("frozen map", q, slave_activate[31:0])
		ce <= 1'b1;
		@(posedge clk_sys);
	endtask

	// verdict and end of run
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		repeat (30000) @(posedge clk_sys);
		num_errors++;
		give_verdict();
	end

	// main sequence
	initial begin
		{hsel, hsel2, hwrite, slow, tgt} = 5'h00;
		ce = 1'b1;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'h0;
		hsize = 3'h2;
		num_errors = 0;
		check_count = 0;
		rst = 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		walk(1'b0, 1'b0, 32'h0000_0000);
		t_store();
		walk(1'b1, 1'b1, 32'h0000_0006);
		t_bad();
		t_prot();
		give_verdict();
	end
endmodule // store_total_config_cmd_bench
`default_nettype wire
